// >>> core/frame_crc_pkg.sv
package frame_crc_pkg;
  // initialization byte layout
  localparam int INIT_CLASS_BIT = 7;
  localparam int REQ_LSB = 4;
  localparam int REQ_W = 3;
  localparam int SIZE_W = 3;
  localparam int RSP_LEN_W = 7;
  localparam logic [2:0] REQ_SINGLE_RD = 3'h0;
  localparam logic [2:0] REQ_SINGLE_WR = 3'h1;
  localparam logic [7:0] RD_INIT_BYTE = 8'h80;
  localparam logic [3:0] WR_INIT_HI = 4'h9;
  localparam int MAX_WR_BYTES = 8;
  localparam int WR_IDX_W = 3;
  localparam int RD_CNT_W = 7;
  // crc: reflected form of x^16+x^15+x^2+1, preset all ones
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    RX_INIT = 3'b000,
    RX_DEV = 3'b001,
    RX_AHI = 3'b011,
    RX_ALO = 3'b010,
    RX_DATA = 3'b110,
    RX_CRC0 = 3'b111,
    RX_CRC1 = 3'b101
  } rx_state_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b000,
    RS_HDR = 3'b001,
    RS_RD = 3'b011,
    RS_WAIT = 3'b010,
    RS_EMIT = 3'b110,
    RS_CRC0 = 3'b111,
    RS_CRC1 = 3'b101
  } rsp_state_t;
endpackage : frame_crc_pkg

// >>> core/crc16_refl_engine.sv
module crc16_refl_engine
  import frame_crc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // byte stream
  input wire logic byte_valid,
  input wire logic first_byte,
  input wire logic [7:0] byte_data,
  // remainder, in reflected register order
  output logic [15:0] crc_q
);
  // shifting right walks each byte lsb first, so no bit reversal is needed
  function automatic logic [15:0] step8(input logic [15:0] c,
                                         input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : step8

  // preset folds the ones into the first 16 bits; no zero tail is shifted
  // in, so the register is the final remainder both when generating and
  // when checking a frame with its crc appended
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      crc_q <= CRC_PRESET;
    end else if (clk_en && byte_valid) begin
      crc_q <= step8(first_byte ? CRC_PRESET : crc_q, byte_data);
    end
  end
endmodule : crc16_refl_engine

// >>> core/daisy_chain_frame_crc.sv
module daisy_chain_frame_crc
  import frame_crc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // configuration
  input wire logic [7:0] dev_addr,
  input wire logic dev_addr_set,
  // received chain bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // forwarded chain bytes
  output logic fwd_valid_q,
  output logic [7:0] fwd_data_q,
  // register write port
  output logic reg_wr_en_q,
  output logic [15:0] reg_wr_addr_q,
  output logic [7:0] reg_wr_data_q,
  // register read port, data valid the cycle after the strobe
  output logic reg_rd_en_q,
  output logic [15:0] reg_rd_addr_q,
  input wire logic [7:0] reg_rd_data,
  // response bytes
  output logic rsp_valid_q,
  output logic [7:0] rsp_data_q,
  // status
  output logic frame_ok_q,
  output logic frame_bad_q,
  output logic crc_fault_q,
  input wire logic crc_fault_clr
);
  import frame_crc_pkg::*;

  function automatic logic [REQ_W-1:0] req_of(input logic [7:0] b);
    return b[REQ_LSB +: REQ_W];
  endfunction : req_of

  function automatic logic has_dev_field(input logic [7:0] b);
    return !b[INIT_CLASS_BIT] || (req_of(b) == REQ_SINGLE_RD) ||
           (req_of(b) == REQ_SINGLE_WR);
  endfunction : has_dev_field

  // data bytes minus one: response length, write count, or one byte
  function automatic logic [RD_CNT_W-1:0] data_len_m1(input logic [7:0] b);
    if (!b[INIT_CLASS_BIT]) begin
      return b[RSP_LEN_W-1:0];
    end else if (b[REQ_LSB]) begin
      return {{(RD_CNT_W-SIZE_W){1'b0}}, b[SIZE_W-1:0]};
    end
    return '0;
  endfunction : data_len_m1

  rx_state_t rx_q;
  logic [7:0] init_q;
  logic [7:0] fdev_q;
  logic [15:0] faddr_q;
  logic [RD_CNT_W-1:0] left_q;
  logic [RD_CNT_W-1:0] rd_cnt_q;
  logic [7:0] wbuf_q [MAX_WR_BYTES];
  logic [WR_IDX_W-1:0] widx_q;
  logic done_q;
  logic rx_crc_first;
  logic [15:0] rx_crc;

  assign rx_crc_first = (rx_q == RX_INIT);

  crc16_refl_engine u_rx_crc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .byte_valid(rx_valid),
    .first_byte(rx_crc_first),
    .byte_data(rx_data),
    .crc_q(rx_crc)
  );

  // every byte is passed on, one cycle late, whatever it addresses
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fwd_valid_q <= 1'b0;
      fwd_data_q <= BYTE_RST;
    end else if (clk_en) begin
      fwd_valid_q <= rx_valid;
      fwd_data_q <= rx_valid ? rx_data : fwd_data_q;
    end
  end

  // frame parser; lengths come from the initialization byte
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= RX_INIT;
      init_q <= BYTE_RST;
      fdev_q <= BYTE_RST;
      faddr_q <= ADDR_RST;
      left_q <= '0;
      rd_cnt_q <= '0;
      widx_q <= '0;
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (rx_valid) begin
        case (rx_q)
          RX_INIT: begin
            init_q <= rx_data;
            left_q <= data_len_m1(rx_data);
            widx_q <= '0;
            rx_q <= has_dev_field(rx_data) ? RX_DEV : RX_AHI;
          end
          RX_DEV: begin
            fdev_q <= rx_data;
            rx_q <= RX_AHI;
          end
          RX_AHI: begin
            faddr_q[15:8] <= rx_data;
            rx_q <= RX_ALO;
          end
          RX_ALO: begin
            faddr_q[7:0] <= rx_data;
            rx_q <= RX_DATA;
          end
          RX_DATA: begin
            wbuf_q[widx_q] <= rx_data;
            widx_q <= widx_q + 1'b1;
            rd_cnt_q <= rx_data[RD_CNT_W-1:0];
            left_q <= left_q - 1'b1;
            if (left_q == '0) begin
              rx_q <= RX_CRC0;
            end
          end
          RX_CRC0: begin
            rx_q <= RX_CRC1;
          end
          RX_CRC1: begin
            rx_q <= RX_INIT;
            done_q <= 1'b1;
          end
          default: begin
            rx_q <= RX_INIT;
          end
        endcase
      end
    end
  end

  logic crc_good;
  logic is_cmd;
  logic addr_hit;
  logic do_write;
  logic do_read;

  // the engine has already taken the last crc byte when done_q is high
  assign crc_good = (rx_crc == CRC_GOOD);
  assign is_cmd = init_q[INIT_CLASS_BIT];
  assign addr_hit = dev_addr_set && (fdev_q == dev_addr);
  assign do_write = done_q && crc_good && is_cmd && addr_hit &&
                    (req_of(init_q) == REQ_SINGLE_WR);
  assign do_read = done_q && crc_good && addr_hit &&
                   (init_q == RD_INIT_BYTE);

  // status pulses and sticky fault; a new error wins over a clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_ok_q <= 1'b0;
      frame_bad_q <= 1'b0;
      crc_fault_q <= 1'b0;
    end else if (clk_en) begin
      frame_ok_q <= done_q && crc_good;
      frame_bad_q <= done_q && !crc_good;
      if (done_q && !crc_good) begin
        crc_fault_q <= 1'b1;
      end else if (crc_fault_clr) begin
        crc_fault_q <= 1'b0;
      end
    end
  end

  // write burst; the 3-bit count field cannot exceed eight bytes
  logic wr_busy_q;
  logic [WR_IDX_W-1:0] wr_pos_q;
  logic [WR_IDX_W-1:0] wr_last_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_busy_q <= 1'b0;
      wr_pos_q <= '0;
      wr_last_q <= '0;
      reg_wr_en_q <= 1'b0;
      reg_wr_addr_q <= ADDR_RST;
      reg_wr_data_q <= BYTE_RST;
    end else if (clk_en) begin
      reg_wr_en_q <= 1'b0;
      if (do_write && !wr_busy_q) begin
        wr_busy_q <= 1'b1;
        wr_pos_q <= '0;
        wr_last_q <= init_q[SIZE_W-1:0];
      end else if (wr_busy_q) begin
        reg_wr_en_q <= 1'b1;
        reg_wr_addr_q <= faddr_q + {{(16-WR_IDX_W){1'b0}}, wr_pos_q};
        reg_wr_data_q <= wbuf_q[wr_pos_q];
        wr_pos_q <= wr_pos_q + 1'b1;
        if (wr_pos_q == wr_last_q) begin
          wr_busy_q <= 1'b0;
        end
      end
    end
  end

  // read response: header, register bytes, then crc
  rsp_state_t rs_q;
  logic [1:0] hdr_q;
  logic [RD_CNT_W-1:0] rs_left_q;
  logic [RD_CNT_W-1:0] rs_len_q;
  logic [15:0] rs_addr_q;
  logic [15:0] rs_base_q;
  logic [7:0] rs_dev_q;
  logic tx_crc_first;
  logic tx_feed;
  logic [7:0] tx_byte;
  logic [15:0] tx_crc;

  function automatic logic [7:0] hdr_byte(input logic [1:0] i,
                                          input logic [RD_CNT_W-1:0] n,
                                          input logic [7:0] d,
                                          input logic [15:0] a);
    case (i)
      2'h0: return {1'b0, n};
      2'h1: return d;
      2'h2: return a[15:8];
      default: return a[7:0];
    endcase
  endfunction : hdr_byte

  assign tx_feed = (rs_q == RS_HDR) || (rs_q == RS_EMIT);
  assign tx_crc_first = (rs_q == RS_HDR) && (hdr_q == 2'h0);
  assign tx_byte = (rs_q == RS_HDR) ?
                   hdr_byte(hdr_q, rs_len_q, rs_dev_q, rs_base_q) :
                   reg_rd_data;

  crc16_refl_engine u_tx_crc (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .byte_valid(tx_feed),
    .first_byte(tx_crc_first),
    .byte_data(tx_byte),
    .crc_q(tx_crc)
  );

  // one read at a time; a read arriving while answering is dropped,
  // since the chain cannot carry two answers from one device anyway
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rs_q <= RS_IDLE;
      hdr_q <= 2'h0;
      rs_left_q <= '0;
      rs_len_q <= '0;
      rs_addr_q <= ADDR_RST;
      rs_base_q <= ADDR_RST;
      rs_dev_q <= BYTE_RST;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= BYTE_RST;
      reg_rd_en_q <= 1'b0;
      reg_rd_addr_q <= ADDR_RST;
    end else if (clk_en) begin
      rsp_valid_q <= 1'b0;
      reg_rd_en_q <= 1'b0;
      case (rs_q)
        RS_IDLE: begin
          if (do_read) begin
            rs_len_q <= rd_cnt_q;
            rs_left_q <= rd_cnt_q;
            rs_base_q <= faddr_q;
            rs_addr_q <= faddr_q;
            rs_dev_q <= dev_addr;
            hdr_q <= 2'h0;
            rs_q <= RS_HDR;
          end
        end
        RS_HDR: begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= tx_byte;
          hdr_q <= hdr_q + 1'b1;
          if (hdr_q == 2'h3) begin
            rs_q <= RS_RD;
          end
        end
        RS_RD: begin
          reg_rd_en_q <= 1'b1;
          reg_rd_addr_q <= rs_addr_q;
          rs_q <= RS_WAIT;
        end
        RS_WAIT: begin
          rs_q <= RS_EMIT;
        end
        RS_EMIT: begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= reg_rd_data;
          rs_addr_q <= rs_addr_q + 1'b1;
          rs_left_q <= rs_left_q - 1'b1;
          rs_q <= (rs_left_q == '0) ? RS_CRC0 : RS_RD;
        end
        RS_CRC0: begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= tx_crc[7:0];
          rs_q <= RS_CRC1;
        end
        RS_CRC1: begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= tx_crc[15:8];
          rs_q <= RS_IDLE;
        end
        default: begin
          rs_q <= RS_IDLE;
        end
      endcase
    end
  end
endmodule : daisy_chain_frame_crc

// >>> verification/chain_host_model.sv
module chain_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // chain bytes toward the device
  output logic rx_valid,
  output logic [7:0] rx_data,
  // register file behind the device
  input wire logic reg_rd_en_q,
  input wire logic [15:0] reg_rd_addr_q,
  output logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_due_q;
  logic [7:0] rd_val_q;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end

  // bytes leave back to back; between frames the data lines show the
  // inverse of the last byte so a stale value can never pass for a new one
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_data <= ~q[q.size()-1];
  endtask : send

  // read data is good only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_due_q <= 1'b0;
      rd_val_q <= 8'h00;
    end else begin
      rd_due_q <= reg_rd_en_q;
      if (reg_rd_en_q) begin
        // both address bytes shape the value, so a wrong high byte shows
        rd_val_q <= reg_rd_addr_q[7:0] ^ reg_rd_addr_q[15:8] ^ 8'h3C;
      end
    end
  end
  assign reg_rd_data = rd_due_q ? rd_val_q : ~rd_val_q;
endmodule : chain_host_model

// >>> verification/frame_crc_properties.sv
module frame_crc_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // chain
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic fwd_valid_q,
  input wire logic [7:0] fwd_data_q,
  // register ports
  input wire logic reg_wr_en_q,
  input wire logic [15:0] reg_wr_addr_q,
  input wire logic reg_rd_en_q,
  // response and status
  input wire logic rsp_valid_q,
  input wire logic frame_ok_q,
  input wire logic frame_bad_q,
  input wire logic crc_fault_q,
  input wire logic crc_fault_clr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] wr_run_q;

  // run length of write pulses; a nibble leaves room above the cap of 8
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_run_q <= 4'h0;
    end else begin
      wr_run_q <= reg_wr_en_q ? wr_run_q + 4'h1 : 4'h0;
    end
  end

  property p_fwd_valid;
    clk_en && rx_valid |=> fwd_valid_q;
  endproperty
  a_fwd_valid: assert property (p_fwd_valid)
    else $error("byte not forwarded");
  property p_fwd_data;
    clk_en && rx_valid |=> fwd_data_q == $past(rx_data);
  endproperty
  a_fwd_data: assert property (p_fwd_data)
    else $error("forwarded byte differs");
  property p_fwd_quiet;
    clk_en && !rx_valid |=> !fwd_valid_q;
  endproperty
  a_fwd_quiet: assert property (p_fwd_quiet)
    else $error("forward without a byte");
  property p_ok_bad;
    !(frame_ok_q && frame_bad_q);
  endproperty
  a_ok_bad: assert property (p_ok_bad)
    else $error("frame both good and bad");
  property p_bad_sets;
    frame_bad_q |-> crc_fault_q;
  endproperty
  a_bad_sets: assert property (p_bad_sets)
    else $error("crc fault not flagged");
  property p_sticky;
    crc_fault_q && !crc_fault_clr |=> crc_fault_q;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("crc fault dropped");
  property p_clear;
    clk_en && crc_fault_clr |=> !crc_fault_q || frame_bad_q;
  endproperty
  a_clear: assert property (p_clear)
    else $error("crc fault not cleared");
  property p_wr_after_ok;
    $rose(reg_wr_en_q) |->
      $past(frame_ok_q) || $past(frame_ok_q, 2) || $past(frame_ok_q, 3);
  endproperty
  a_wr_after_ok: assert property (p_wr_after_ok)
    else $error("write without a good frame");
  property p_wr_cap;
    reg_wr_en_q |-> wr_run_q < 4'h8;
  endproperty
  a_wr_cap: assert property (p_wr_cap)
    else $error("write burst over eight");
  property p_wr_step;
    reg_wr_en_q && $past(reg_wr_en_q) |->
      reg_wr_addr_q == $past(reg_wr_addr_q) + 16'h0001;
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write address not consecutive");
  property p_rd_rsp;
    clk_en && reg_rd_en_q |-> ##2 rsp_valid_q;
  endproperty
  a_rd_rsp: assert property (p_rd_rsp)
    else $error("read byte not sent");
endmodule : frame_crc_checker

bind daisy_chain_frame_crc frame_crc_checker frame_crc_checker_i (
  .clk_sys, .rst_b, .clk_en, .rx_valid, .rx_data, .fwd_valid_q,
  .fwd_data_q, .reg_wr_en_q, .reg_wr_addr_q, .reg_rd_en_q, .rsp_valid_q,
  .frame_ok_q, .frame_bad_q, .crc_fault_q, .crc_fault_clr
);

// >>> verification/daisy_chain_frame_crc_tb.sv
`define CHK(n, x, y) \
  begin \
    num_checks++; \
    if ((y) !== (x)) begin \
      err_total++; \
      $display("[ERR] %s exp %0h got %0h", n, x, y); \
    end \
  end

module daisy_chain_frame_crc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_crc_pkg::*;
  logic clk_sys, rst_b, clk_en, dev_addr_set, crc_fault_clr, rx_valid;
  logic fwd_valid_q, reg_wr_en_q, reg_rd_en_q, rsp_valid_q;
  logic frame_ok_q, frame_bad_q, crc_fault_q;
  logic [7:0] dev_addr, rx_data, fwd_data_q, reg_wr_data_q;
  logic [7:0] reg_rd_data, rsp_data_q;
  logic [15:0] reg_wr_addr_q, reg_rd_addr_q;
  logic [23:0] wr_log[$];
  logic [7:0] rsp_log[$], fwd_log[$];
  int err_total, num_checks, ok_cnt, bad_cnt;

  daisy_chain_frame_crc daisy_chain_frame_crc_i (
    .clk_sys, .rst_b, .clk_en, .dev_addr, .dev_addr_set, .rx_valid,
    .rx_data, .fwd_valid_q, .fwd_data_q, .reg_wr_en_q, .reg_wr_addr_q,
    .reg_wr_data_q, .reg_rd_en_q, .reg_rd_addr_q, .reg_rd_data,
    .rsp_valid_q, .rsp_data_q, .frame_ok_q, .frame_bad_q, .crc_fault_q,
    .crc_fault_clr
  );
  chain_host_model chain_host_model_i (
    .clk_sys, .rst_b, .rx_valid, .rx_data, .reg_rd_en_q, .reg_rd_addr_q,
    .reg_rd_data
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (reg_wr_en_q) wr_log.push_back({reg_wr_addr_q, reg_wr_data_q});
    if (rsp_valid_q) rsp_log.push_back(rsp_data_q);
    if (fwd_valid_q) fwd_log.push_back(fwd_data_q);
    if (frame_ok_q) ok_cnt++;
    if (frame_bad_q) bad_cnt++;
  end

  // reflected shift register, low byte goes out first
  function automatic void seal(ref logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction : seal

  task automatic send(input logic [7:0] q[$], input int tail);
    wr_log.delete();
    rsp_log.delete();
    fwd_log.delete();
    ok_cnt = 0;
    bad_cnt = 0;
    chain_host_model_i.send(q);
    repeat (tail) @(posedge clk_sys);
    `CHK("fwd count", q.size(), fwd_log.size())
    foreach (q[i]) `CHK("fwd byte", q[i], fwd_log[i])
  endtask : send

  task automatic chk_rsp(input logic [7:0] e[$]);
    `CHK("rsp len", e.size(), rsp_log.size())
    foreach (e[i]) `CHK("rsp byte", e[i], rsp_log[i])
  endtask : chk_rsp

  task automatic t_write_doc();
    logic [7:0] d[$] = {8'h02, 8'hB7, 8'h78, 8'hBC};
    send({8'h93, 8'h02, 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC,
          8'hB8, 8'hAE}, 16);
    `CHK("ok", 1, ok_cnt)
    `CHK("wr count", 4, wr_log.size())
    foreach (d[i]) `CHK("wr", {16'h0300 + 16'(i), d[i]}, wr_log[i])
  endtask : t_write_doc

  task automatic t_write_max();
    logic [7:0] q[$] = {8'h97, 8'h02, 8'h10, 8'hFC};
    for (int i = 0; i < 8; i++) q.push_back(8'hA0 + 8'(i));
    seal(q);
    send(q, 20);
    `CHK("wr count", 8, wr_log.size())
    for (int i = 0; i < 8; i++)
      `CHK("wr", {16'h10FC + 16'(i), 8'hA0 + 8'(i)}, wr_log[i])
  endtask : t_write_max

  task automatic t_bad_crc();
    send({8'h93, 8'h02, 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC,
          8'hB8, 8'hAF}, 16);
    `CHK("bad", 1, bad_cnt)
    `CHK("ok", 0, ok_cnt)
    `CHK("wr count", 0, wr_log.size())
    `CHK("fault", 1'b1, crc_fault_q)
    // a clear while the clock enable is low must not reach the flag
    clk_en <= 1'b0;
    crc_fault_clr <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("fault frozen", 1'b1, crc_fault_q)
    clk_en <= 1'b1;
    @(posedge clk_sys);
    crc_fault_clr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("fault clr", 1'b0, crc_fault_q)
  endtask : t_bad_crc

  task automatic t_foreign();
    logic [7:0] w[$] = {8'h90, 8'h03, 8'h00, 8'h20, 8'h55};
    logic [7:0] r[$] = {8'h80, 8'h03, 8'h00, 8'h20, 8'h01};
    seal(w);
    seal(r);
    send(w, 16);
    `CHK("ok", 1, ok_cnt)
    `CHK("wr count", 0, wr_log.size())
    send(r, 24);
    `CHK("rsp len", 0, rsp_log.size())
  endtask : t_foreign

  task automatic t_other();
    logic [7:0] s[$] = {8'hB1, 8'h03, 8'h00, 8'h11, 8'h22};
    logic [7:0] p[$] = {8'h01, 8'h02, 8'h05, 8'h68, 8'hAA, 8'hBB};
    seal(s);
    seal(p);
    // no device byte in this class: a wrong length would break the crc
    send(s, 16);
    `CHK("ok", 1, ok_cnt)
    `CHK("wr count", 0, wr_log.size())
    // a passing response frame is forwarded and never executed
    send(p, 24);
    `CHK("ok", 1, ok_cnt)
    `CHK("wr count", 0, wr_log.size())
    `CHK("rsp len", 0, rsp_log.size())
  endtask : t_other

  task automatic t_read_doc();
    logic [7:0] e[$] = {8'h1F, 8'h02, 8'h05, 8'h68};
    for (int i = 0; i < 32; i++)
      e.push_back((8'h68 + 8'(i)) ^ 8'h05 ^ 8'h3C);
    seal(e);
    send({8'h80, 8'h02, 8'h05, 8'h68, 8'h1F, 8'h5A, 8'h6F}, 120);
    chk_rsp(e);
  endtask : t_read_doc

  task automatic t_read_one();
    logic [7:0] q[$] = {8'h80, 8'h02, 8'h00, 8'h40, 8'h00};
    logic [7:0] e[$] = {8'h00, 8'h02, 8'h00, 8'h40, 8'h7C};
    seal(q);
    seal(e);
    send(q, 24);
    chk_rsp(e);
  endtask : t_read_one

  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (4000) @(posedge clk_sys);
    err_total++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    dev_addr = 8'h02;
    dev_addr_set = 1'b0;
    crc_fault_clr = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    dev_addr_set <= 1'b1;
    @(posedge clk_sys);
    t_write_doc();
    t_write_max();
    t_bad_crc();
    t_foreign();
    t_other();
    t_read_doc();
    t_read_one();
    results();
  end
endmodule : daisy_chain_frame_crc_tb
